// ===== design/notify_pkg.sv
// constants, register map and types shared by the notification framer
// assumes one 200 MHz clock domain and an 8-bit register port
package notify_pkg;

    // register port geometry
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned NPINS    = 6;

    // register offsets
    localparam logic [3:0] ADDR_NOTIFY_EN = 4'h0;
    localparam logic [3:0] ADDR_CTRL      = 4'h1;
    localparam logic [3:0] ADDR_PIN_MASK  = 4'h2;
    localparam logic [3:0] ADDR_PIN_STATE = 4'h3;
    localparam logic [3:0] ADDR_DATA_LO   = 4'h4;
    localparam logic [3:0] ADDR_DATA_HI   = 4'h5;
    localparam logic [3:0] ADDR_EVT_STAT  = 4'h6;
    localparam logic [3:0] ADDR_EVT_EN    = 4'h7;

    // reset values and writable-bit masks
    localparam logic [7:0] NOTIFY_EN_RST  = 8'h00;
    localparam logic [7:0] NOTIFY_EN_WM   = 8'h7B;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] PIN_MASK_RST   = 8'h3F;
    localparam logic [7:0] EVT_EN_RST     = 8'h00;
    localparam int unsigned CTRL_VMAP     = 0;

    // notification-enable bit positions
    localparam int unsigned EN_PIN1 = 1 - 1;
    localparam int unsigned EN_PIN2 = 1;
    localparam int unsigned EN_PIN0 = 3;
    localparam int unsigned EN_PIN3 = 4;
    localparam int unsigned EN_PIN4 = 5;
    localparam int unsigned EN_PIN5 = 6;

    // status data field bit positions
    localparam int unsigned D_CD   = 0;
    localparam int unsigned D_DSR  = 1;
    localparam int unsigned D_BRK  = 2;
    localparam int unsigned D_RI   = 3;
    localparam int unsigned D_FRM  = 4;
    localparam int unsigned D_PAR  = 5;
    localparam int unsigned D_OVR  = 6;
    localparam int unsigned D_PIN1 = 8;
    localparam int unsigned D_PIN2 = 9;
    localparam int unsigned D_PIN0 = 11;
    localparam int unsigned D_PIN3 = 12;
    localparam int unsigned D_PIN4 = 13;
    localparam int unsigned D_PIN5 = 14;

    // packet layout
    localparam logic [7:0]  REQ_TYPE     = 8'hA1;
    localparam logic [7:0]  NOTIF_SSTATE = 8'h20;
    localparam logic [15:0] WVALUE       = 16'h0000;
    localparam logic [15:0] WINDEX       = 16'h0000;
    localparam logic [15:0] WLENGTH      = 16'h0002;
    localparam logic [3:0]  OFS_REQ      = 4'h0;
    localparam logic [3:0]  OFS_NOTIF    = 4'h1;
    localparam logic [3:0]  OFS_VAL      = 4'h2;
    localparam logic [3:0]  OFS_IDX      = 4'h4;
    localparam logic [3:0]  OFS_LEN      = 4'h6;
    localparam logic [3:0]  OFS_DATA     = 4'h8;
    localparam logic [3:0]  OFS_LAST     = 4'h9;

    // event status bits
    localparam int unsigned EVT_SENT = 0;
    localparam int unsigned EVT_PIN  = 1;
    localparam int unsigned EVT_LINE = 2;
    localparam int unsigned EVT_W    = 3;

    typedef enum logic {SER_IDLE, SER_SEND} ser_state_t;

endpackage : notify_pkg

// ===== design/notify_if.sv
// handshake between the packet scheduler and the byte serialiser
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface notify_if;
    logic        start;  // one-cycle launch request
    logic [15:0] word;   // status data field to send
    logic        busy;   // packet in flight
    logic        done;   // one-cycle pulse after last byte
    modport ctrl (output start, output word, input busy, input done);
    modport ser  (input start, input word, output busy, output done);
endinterface : notify_if

// ===== design/notify_serializer.sv
// byte serialiser for the ten-byte serial-state notification
// assumes the endpoint engine takes a byte on valid and ready together
`timescale 1ns/1ps
module notify_serializer
    import notify_pkg::*;
(
    input  wire logic CLOCK,
    input  wire logic RSTN,
    notify_if.ser     nif,
    output logic [7:0] PKT_DATA,
    output logic       PKT_VALID,
    output logic       PKT_LAST,
    input  wire logic  PKT_READY
);
    ser_state_t  state_reg;  // idle or sending
    logic [3:0]  idx_reg;    // offset of byte on the port
    logic [15:0] word_reg;   // data field frozen at launch
    logic [7:0]  data_reg;   // byte on the port
    logic        done_reg;   // end-of-packet pulse

    // fixed header bytes, multi-byte fields low byte first
    function automatic logic [7:0] pkt_byte(input logic [3:0] i,
                                            input logic [15:0] w);
        case (i)
            OFS_REQ:      pkt_byte = REQ_TYPE;      // RULE_05
            OFS_NOTIF:    pkt_byte = NOTIF_SSTATE;  // RULE_06
            OFS_VAL:      pkt_byte = WVALUE[7:0];   // RULE_07
            OFS_VAL + 1:  pkt_byte = WVALUE[15:8];
            OFS_IDX:      pkt_byte = WINDEX[7:0];   // RULE_07
            OFS_IDX + 1:  pkt_byte = WINDEX[15:8];
            OFS_LEN:      pkt_byte = WLENGTH[7:0];  // RULE_08
            OFS_LEN + 1:  pkt_byte = WLENGTH[15:8];
            OFS_DATA:     pkt_byte = w[7:0];        // RULE_19
            OFS_LAST:     pkt_byte = w[15:8];
            default:      pkt_byte = 8'h00;
        endcase
    endfunction : pkt_byte

    wire take = (state_reg == SER_SEND) && PKT_READY;
    wire last = (idx_reg == OFS_LAST);
    wire [3:0] idx_inc = idx_reg + 4'h1;

    // walk the offsets upward, one byte per accepted beat
    always_ff @(posedge CLOCK) begin
        done_reg <= 1'b0;
        if (!RSTN) begin
            state_reg <= SER_IDLE;
            idx_reg   <= OFS_REQ;
            word_reg  <= 16'h0000;
            data_reg  <= 8'h00;
        end else if (state_reg == SER_IDLE) begin
            if (nif.start) begin
                state_reg <= SER_SEND;
                idx_reg   <= OFS_REQ;
                word_reg  <= nif.word;
                data_reg  <= pkt_byte(OFS_REQ, nif.word);
            end
        end else if (take) begin
            if (last) begin
                state_reg <= SER_IDLE;            // RULE_19
                done_reg  <= 1'b1;
            end else begin
                idx_reg  <= idx_inc;              // RULE_19
                data_reg <= pkt_byte(idx_inc, word_reg);
            end
        end
    end

    assign PKT_DATA  = data_reg;
    assign PKT_VALID = (state_reg == SER_SEND);
    assign PKT_LAST  = PKT_VALID && last;
    assign nif.busy  = (state_reg != SER_IDLE);
    assign nif.done  = done_reg;

endmodule : notify_serializer

// ===== design/serial_state_notify_packet.sv
// serial-state notification framer: builds and launches the packet
// assumes pins and modem lines are asynchronous, UART flags are local
//
// What this block does
// [RULE_01] enable bit 4 reports general pin 3
// [RULE_02] enable bit 5 reports general pin 4
// [RULE_03] enable bit 6 reports general pin 5
// [RULE_04] software keeps enable bit 7 zero
// [RULE_05] byte 0 is request type A1
// [RULE_06] byte 1 is serial-state code 20
// [RULE_07] value and index fields are zero
// [RULE_08] length field two, data at offset 8
// [RULE_09] overrun D6, parity D5, framing D4
// [RULE_10] ring D3, break D2, DSR D1, CD D0
// [RULE_11] standard packet zeroes D15 through D7
// [RULE_12] overrun bit set on discarded data
// [RULE_13] carrier bits follow DSR and CD lines
// [RULE_14] pins 5,4,3,0 at D14,D13,D12,D11
// [RULE_15] pins 2,1 at D9,D8; rest zero
// [RULE_16] enable bits 0,1,3 report pins 1,2,0
// [RULE_17] unmasked input pin change sends packet
// [RULE_18] disabled pin reports zero in field
// [RULE_19] bytes ascending, low byte first, one transfer
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module serial_state_notify_packet
    import notify_pkg::*;
(
    input  wire logic              CLOCK,
    input  wire logic              RSTN,
    // register port
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [7:0]        REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output logic [7:0]             REG_RDATA,
    // general pins and their direction (1 = output)
    input  wire logic [NPINS-1:0]  GEN_PIN,
    input  wire logic [NPINS-1:0]  PIN_DIR,
    // modem lines from pins
    input  wire logic              RING_LINE,
    input  wire logic              DSR_LINE,
    input  wire logic              CD_LINE,
    // line events from the local UART
    input  wire logic              OVERRUN_PULSE,
    input  wire logic              PARITY_PULSE,
    input  wire logic              FRAMING_PULSE,
    input  wire logic              BREAK_STATE,
    // interrupt endpoint byte stream
    output logic [7:0]             PKT_DATA,
    output logic                   PKT_VALID,
    output logic                   PKT_LAST,
    input  wire logic              PKT_READY,
    // level interrupt
    output logic                   IRQ
);

    // ---------------- synchronisers ----------------
    localparam int unsigned SYNC_W = NPINS + 3;

    logic [SYNC_W-1:0] meta_reg;  // first stage, read by stage two only
    logic [SYNC_W-1:0] sync_reg;  // second stage, safe to use
    logic [SYNC_W-1:0] prev_reg;  // last seen synchronised value

    // async pins pass two flops before any logic sees them
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= {CD_LINE, DSR_LINE, RING_LINE, GEN_PIN};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // named views of the synchronised vector
    wire [NPINS-1:0] pin_s  = sync_reg[NPINS-1:0];
    wire             ring_s = sync_reg[NPINS];
    wire             dsr_s  = sync_reg[NPINS+1];
    wire             cd_s   = sync_reg[NPINS+2];

    // ---------------- registers ----------------
    logic [7:0] notify_pin_status_enable_reg; // per-pin report enable
    logic [7:0] ctrl_reg;                     // vendor mapping switch
    logic [7:0] pin_mask_reg;                 // 1 = pin change silent
    logic [EVT_W-1:0] evt_stat_reg;           // sticky event bits
    logic [EVT_W-1:0] evt_en_reg;             // interrupt enables
    logic [7:0] rdata_reg;                    // read data, one cycle late

    // write decode
    wire wr_en   = REG_WR && (REG_ADDR == ADDR_NOTIFY_EN);
    wire wr_ctrl = REG_WR && (REG_ADDR == ADDR_CTRL);
    wire wr_mask = REG_WR && (REG_ADDR == ADDR_PIN_MASK);
    wire wr_stat = REG_WR && (REG_ADDR == ADDR_EVT_STAT);
    wire wr_ien  = REG_WR && (REG_ADDR == ADDR_EVT_EN);

    // reserved enable bits 7 and 2 never store, so they read zero;
    // software is still expected to write them as zero
    wire [7:0] en_wdata = REG_WDATA & NOTIFY_EN_WM; // RULE_04 RULE_16

    // software-owned configuration
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            notify_pin_status_enable_reg <= NOTIFY_EN_RST;
            ctrl_reg     <= CTRL_RST;
            pin_mask_reg <= PIN_MASK_RST;
            evt_en_reg   <= EVT_EN_RST[EVT_W-1:0];
        end else begin
            if (wr_en)
                notify_pin_status_enable_reg <= en_wdata;
            if (wr_ctrl)
                ctrl_reg <= REG_WDATA;
            if (wr_mask)
                pin_mask_reg <= REG_WDATA & PIN_MASK_RST;
            if (wr_ien)
                evt_en_reg <= REG_WDATA[EVT_W-1:0];
        end
    end

    // ---------------- change detection ----------------
    // only pins set as inputs and unmasked may trigger a packet
    wire [NPINS-1:0] pin_edge = pin_s ^ prev_reg[NPINS-1:0];
    wire [NPINS-1:0] pin_trig = pin_edge & ~PIN_DIR
                                & ~pin_mask_reg[NPINS-1:0]; // RULE_17
    wire             pin_hit  = |pin_trig;                  // RULE_17

    // modem lines and break state also warrant a fresh report
    logic brk_prev_reg; // break state one cycle ago
    always_ff @(posedge CLOCK) begin
        if (!RSTN)
            brk_prev_reg <= 1'b0;
        else
            brk_prev_reg <= BREAK_STATE;
    end

    wire line_edge = (sync_reg[SYNC_W-1:NPINS]
                      != prev_reg[SYNC_W-1:NPINS])
                     || (BREAK_STATE != brk_prev_reg);
    wire err_pulse = OVERRUN_PULSE || PARITY_PULSE || FRAMING_PULSE;
    wire line_hit  = line_edge || err_pulse;

    // ---------------- error latches ----------------
    logic ovr_reg; // data discarded since last report
    logic par_reg; // parity error since last report
    logic frm_reg; // framing error since last report
    logic launch;  // packet taken by serialiser this cycle

    // a flag arriving in the launch cycle survives for the next packet
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            ovr_reg <= 1'b0;
            par_reg <= 1'b0;
            frm_reg <= 1'b0;
        end else begin
            ovr_reg <= (ovr_reg && !launch) || OVERRUN_PULSE; // RULE_12
            par_reg <= (par_reg && !launch) || PARITY_PULSE;
            frm_reg <= (frm_reg && !launch) || FRAMING_PULSE;
        end
    end

    // ---------------- data field ----------------
    logic [15:0] std_word;  // standard field
    logic [15:0] cust_word; // vendor pin bits, high byte only
    logic [15:0] data_word; // field chosen for the next packet
    wire  [7:0]  en = notify_pin_status_enable_reg;
    wire         vmap = ctrl_reg[CTRL_VMAP];

    // standard field: upper bits stay zero
    always_comb begin
        std_word        = 16'h0000;         // RULE_11
        std_word[D_OVR] = ovr_reg;          // RULE_09
        std_word[D_PAR] = par_reg;          // RULE_09
        std_word[D_FRM] = frm_reg;          // RULE_09
        std_word[D_RI]  = ring_s;           // RULE_10
        std_word[D_BRK] = BREAK_STATE;      // RULE_10
        std_word[D_DSR] = dsr_s;            // RULE_10 RULE_13
        std_word[D_CD]  = cd_s;             // RULE_10 RULE_13
    end

    // vendor field: a disabled pin reads zero, D15, D10, D7 stay zero
    always_comb begin
        cust_word         = 16'h0000;                  // RULE_15
        cust_word[D_PIN5] = en[EN_PIN5] && pin_s[5];   // RULE_03 RULE_14
        cust_word[D_PIN4] = en[EN_PIN4] && pin_s[4];   // RULE_02 RULE_14
        cust_word[D_PIN3] = en[EN_PIN3] && pin_s[3];   // RULE_01 RULE_14
        cust_word[D_PIN0] = en[EN_PIN0] && pin_s[0];   // RULE_16 RULE_14
        cust_word[D_PIN2] = en[EN_PIN2] && pin_s[2];   // RULE_16 RULE_15
        cust_word[D_PIN1] = en[EN_PIN1] && pin_s[1];   // RULE_16 RULE_18
    end

    // low seven bits are the same in both forms
    assign data_word = vmap ? (std_word | cust_word) // RULE_15
                            : std_word;              // RULE_11

    // ---------------- scheduling ----------------
    notify_if nif ();

    logic pend_reg;  // a report is owed to the host

    // a trigger during launch keeps the request alive for one more packet
    always_ff @(posedge CLOCK) begin
        if (!RSTN)
            pend_reg <= 1'b0;
        else
            pend_reg <= (pend_reg && !launch) || pin_hit || line_hit;
    end

    // launch as soon as the serialiser is free
    assign launch    = pend_reg && !nif.busy;        // RULE_17
    assign nif.start = launch;
    assign nif.word  = data_word;

    // ---------------- serialiser ----------------
    notify_serializer u_ser (
        .CLOCK     (CLOCK),
        .RSTN      (RSTN),
        .nif       (nif),
        .PKT_DATA  (PKT_DATA),
        .PKT_VALID (PKT_VALID),
        .PKT_LAST  (PKT_LAST),
        .PKT_READY (PKT_READY)
    );

    // ---------------- interrupt status ----------------
    logic [EVT_W-1:0] evt_set; // hardware events this cycle

    always_comb begin
        evt_set           = '0;
        evt_set[EVT_SENT] = nif.done;
        evt_set[EVT_PIN]  = pin_hit;
        evt_set[EVT_LINE] = line_hit;
    end

    // write one to clear; a new event wins over the clear
    always_ff @(posedge CLOCK) begin
        if (!RSTN)
            evt_stat_reg <= '0;
        else if (wr_stat)
            evt_stat_reg <= (evt_stat_reg & ~REG_WDATA[EVT_W-1:0])
                            | evt_set;
        else
            evt_stat_reg <= evt_stat_reg | evt_set;
    end

    assign IRQ = |(evt_stat_reg & evt_en_reg);

    // ---------------- read path ----------------
    logic [7:0] rd_mux; // selected register, zero when unmapped

    always_comb begin
        case (REG_ADDR)
            ADDR_NOTIFY_EN: rd_mux = notify_pin_status_enable_reg;
            ADDR_CTRL:      rd_mux = ctrl_reg;
            ADDR_PIN_MASK:  rd_mux = pin_mask_reg;
            ADDR_PIN_STATE: rd_mux = {2'b00, pin_s};
            ADDR_DATA_LO:   rd_mux = data_word[7:0];
            ADDR_DATA_HI:   rd_mux = data_word[15:8];
            ADDR_EVT_STAT:  rd_mux = {5'h00, evt_stat_reg};
            ADDR_EVT_EN:    rd_mux = {5'h00, evt_en_reg};
            default:        rd_mux = 8'h00;
        endcase
    end

    // data shows in the cycle after the read strobe only
    always_ff @(posedge CLOCK) begin
        if (!RSTN)
            rdata_reg <= 8'h00;
        else if (REG_RD)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 8'h00;
    end

    assign REG_RDATA = rdata_reg;

endmodule : serial_state_notify_packet

// ===== sim/notify_host_model.sv
// host side of the interrupt endpoint: takes packet bytes and keeps
// the last whole packet; assumes one clock shared with the framer
`timescale 1ns/1ps
module notify_host_model (
    input  wire logic       CLOCK,
    input  wire logic       RSTN,
    input  wire logic [7:0] PKT_DATA,
    input  wire logic       PKT_VALID,
    input  wire logic       PKT_LAST,
    input  wire logic       slow,
    output logic            PKT_READY,
    output logic [79:0]     last_pkt,
    output int              pkts
);
    logic [79:0] acc_reg;   // bytes of the packet in progress
    int          idx_reg;   // offset of the next byte
    logic [1:0]  stall_reg; // stall phase, slow host takes one in four

    // a slow host stalls three cycles of four to stretch each byte
    assign PKT_READY = !slow || stall_reg == 2'h3;

    // gather bytes in arrival order, low offset in the low bits
    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            idx_reg   <= 0;
            pkts      <= 0;
            stall_reg <= 2'h0;
            last_pkt  <= 80'h0;
        end else begin
            stall_reg <= stall_reg + 2'h1;
            if (PKT_VALID && PKT_READY) begin
                acc_reg[idx_reg*8 +: 8] <= PKT_DATA;
                idx_reg <= idx_reg + 1;
                if (PKT_LAST) begin
                    last_pkt <= {PKT_DATA, acc_reg[71:0]};
                    pkts     <= pkts + 1;
                    idx_reg  <= 0;
                end
            end
        end
    end
endmodule : notify_host_model

// ===== sim/serial_state_notify_packet_assertions.sv
// port checker for the notification framer, bound to its top module
// assumes one clock domain and the package register map
`timescale 1ns/1ps
module notify_checker
    import notify_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RSTN,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic              REG_RD,
    input wire logic [7:0]        REG_RDATA,
    input wire logic [7:0]        PKT_DATA,
    input wire logic              PKT_VALID,
    input wire logic              PKT_LAST,
    input wire logic              PKT_READY
);
    int unsigned ofs_reg; // offset of the byte now offered

    // count accepted bytes; a dropped valid restarts the count
    always_ff @(posedge CLOCK) begin
        if (!RSTN || !PKT_VALID) begin
            ofs_reg <= 0;
        end else if (PKT_READY) begin
            ofs_reg <= ofs_reg + 1;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    chk_req_type: assert property (
        PKT_VALID && ofs_reg == 0 |-> PKT_DATA == 8'hA1)
        else $error("byte 0 is not the request type");
    chk_notif_code: assert property (
        PKT_VALID && ofs_reg == 1 |-> PKT_DATA == 8'h20)
        else $error("byte 1 is not the notification code");
    chk_zero_fields: assert property (
        PKT_VALID && ofs_reg inside {[2:5]} |-> PKT_DATA == 8'h00)
        else $error("value or index byte not zero");
    chk_length_field: assert property (
        PKT_VALID && ofs_reg inside {6, 7} |->
        PKT_DATA == ((ofs_reg == 6) ? 8'h02 : 8'h00))
        else $error("length field wrong");
    chk_lo_reserved: assert property (
        PKT_VALID && ofs_reg == 8 |-> !PKT_DATA[7])
        else $error("status bit 7 not zero");
    chk_hi_reserved: assert property (
        PKT_VALID && ofs_reg == 9 |-> !PKT_DATA[7] && !PKT_DATA[2])
        else $error("status bit 15 or 10 not zero");
    chk_last_flag: assert property (
        PKT_VALID |-> PKT_LAST == (ofs_reg == 9))
        else $error("last flag not on byte 9");
    chk_byte_hold: assert property (
        PKT_VALID && !PKT_READY |=> PKT_VALID && $stable(PKT_DATA))
        else $error("byte changed before accept");
    chk_single_xfer: assert property (
        PKT_VALID && PKT_READY && !PKT_LAST |=> PKT_VALID)
        else $error("packet broken off early");
    chk_valid_drop: assert property (
        PKT_VALID && PKT_READY && PKT_LAST |=> !PKT_VALID)
        else $error("valid held after last byte");
    chk_rdata_idle: assert property (
        !$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside a read");
    chk_en_reserved: assert property (
        $past(REG_RD) && $past(REG_ADDR) == ADDR_NOTIFY_EN |->
        !REG_RDATA[7] && !REG_RDATA[2])
        else $error("reserved enable bit reads one");
endmodule : notify_checker

bind serial_state_notify_packet notify_checker i_notify_checker (.*);

// ===== sim/serial_state_notify_packet_tb_top.sv
// self-checking bench for the serial-state notification framer
// assumes the host model on the packet stream and the bound checker
`timescale 1ns/1ps
module serial_state_notify_packet_tb_top;
    import notify_pkg::*;
    logic              CLOCK, RSTN, REG_WR, REG_RD, slow;
    logic [ADDR_W-1:0] REG_ADDR;
    logic [7:0]        REG_WDATA, REG_RDATA, PKT_DATA;
    logic [NPINS-1:0]  GEN_PIN, PIN_DIR;
    logic              RING_LINE, DSR_LINE, CD_LINE, BREAK_STATE;
    logic              OVERRUN_PULSE, PARITY_PULSE, FRAMING_PULSE;
    logic              PKT_VALID, PKT_LAST, PKT_READY, IRQ;
    logic [79:0]       last_pkt;  // last whole packet, byte 0 low
    int                pkts, bad_count, compares, seed, cycles, r, base;
    int                vm, en;    // model copy of mapping flag, enables

    // every bench signal carries the name of the port it meets
    serial_state_notify_packet i_serial_state_notify_packet (.*);
    notify_host_model i_notify_host_model (.*);

    // 200 MHz clock
    initial begin
        CLOCK = 1'h0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    // hang guard, far above the run's length
    always @(posedge CLOCK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            $display("timeout after %0d cycles", cycles);
            test_done;
        end
    end

    // expected status field from what the bench drives
    function automatic logic [15:0] exp_word(int errs);
        logic [15:0] w;
        w = {9'h000, errs[2:0], RING_LINE, BREAK_STATE, DSR_LINE, CD_LINE};
        if (vm != 0) begin
            w[14] = GEN_PIN[5] & en[6];
            w[13] = GEN_PIN[4] & en[5];
            w[12] = GEN_PIN[3] & en[4];
            w[11] = GEN_PIN[0] & en[3];
            w[9]  = GEN_PIN[2] & en[1];
            w[8]  = GEN_PIN[1] & en[0];
        end
        return w;
    endfunction : exp_word

    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(logic [3:0] a, logic [7:0] d);
        @(posedge CLOCK);
        REG_ADDR  <= a;
        REG_WDATA <= d;
        REG_WR    <= 1'h1;
        @(posedge CLOCK);
        REG_WR    <= 1'h0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd(logic [3:0] a, logic [7:0] exp, string what);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD   <= 1'h1;
        @(posedge CLOCK);
        REG_RD   <= 1'h0;
        #1;
        chk(what, {56'h0, exp}, {56'h0, REG_RDATA});
    endtask : rd

    // errs bit 2 overrun, bit 1 parity, bit 0 framing
    task automatic pulse(int errs);
        @(posedge CLOCK);
        {OVERRUN_PULSE, PARITY_PULSE, FRAMING_PULSE} <= errs[2:0];
        @(posedge CLOCK);
        {OVERRUN_PULSE, PARITY_PULSE, FRAMING_PULSE} <= 3'h0;
    endtask : pulse

    task automatic wait_pkts(int n);
        int t;
        t = 0;
        while (pkts < n && t < 600) begin
            @(posedge CLOCK);
            t++;
        end
        chk("packet count", n, (pkts < n) ? pkts : n);
    endtask : wait_pkts

    // drain packets from line changes first, then send one and compare
    task automatic shot(int errs);
        repeat (150) @(posedge CLOCK);
        base = pkts;
        pulse(errs);
        wait_pkts(base + 1);
        chk("header", 64'h0002_0000_0000_20A1, last_pkt[63:0]);
        chk("status", exp_word(errs), last_pkt[79:64]);
    endtask : shot

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        {RSTN, REG_WR, REG_RD, slow, RING_LINE, DSR_LINE, CD_LINE} = 7'h0;
        {OVERRUN_PULSE, PARITY_PULSE, FRAMING_PULSE, BREAK_STATE} = 4'h0;
        {REG_ADDR, REG_WDATA, GEN_PIN, PIN_DIR} = 24'h0;
        {bad_count, compares, cycles, vm} = 128'h0;
        seed = 72;
        repeat (4) @(posedge CLOCK);
        RSTN <= 1'h1;
        rd(ADDR_NOTIFY_EN, NOTIFY_EN_RST, "enable reset");
        rd(ADDR_CTRL, CTRL_RST, "control reset");
        rd(ADDR_PIN_MASK, PIN_MASK_RST, "mask reset");
        rd(ADDR_EVT_EN, EVT_EN_RST, "irq enable reset");
        wr(4'h8, 8'hFF);
        rd(4'h8, 8'h00, "unmapped");
        wr(ADDR_NOTIFY_EN, 8'hFF);
        rd(ADDR_NOTIFY_EN, 8'h7B, "enable bits");
        en = 32'h7B;
        $display("registers test done");
        // standard field, enables on but mapping off keeps high byte zero
        for (int i = 0; i < 6; i++) begin
            @(posedge CLOCK);
            r = $random(seed);
            {RING_LINE, DSR_LINE, CD_LINE, BREAK_STATE} <= r[3:0];
            GEN_PIN <= r[9:4];
            slow    <= r[10];
            shot(7 - i);
        end
        $display("standard field test done");
        wr(ADDR_CTRL, 8'h01);
        vm = 1;
        for (int i = 0; i < 10; i++) begin
            r  = $random(seed);
            en = (i == 0) ? 32'h7B : r & 32'h7B;
            wr(ADDR_NOTIFY_EN, en[7:0]);
            GEN_PIN <= r[13:8];
            slow    <= r[14];
            shot(1 + i % 7);
        end
        $display("vendor field test done");
        wr(ADDR_CTRL, 8'h00);
        vm = 0;
        wr(ADDR_PIN_MASK, 8'h3E);
        repeat (150) @(posedge CLOCK);
        base = pkts;
        GEN_PIN[0] <= ~GEN_PIN[0];
        wait_pkts(base + 1);
        GEN_PIN[1] <= ~GEN_PIN[1];
        repeat (150) @(posedge CLOCK);
        chk("masked pin", base + 1, pkts);
        PIN_DIR[0] <= 1'h1;
        GEN_PIN[0] <= ~GEN_PIN[0];
        repeat (150) @(posedge CLOCK);
        chk("output pin", base + 1, pkts);
        PIN_DIR[0] <= 1'h0;
        $display("pin trigger test done");
        // triggers during a packet fold into one pending packet
        slow <= 1'h1;
        repeat (150) @(posedge CLOCK);
        base = pkts;
        pulse(4);
        repeat (3) @(posedge CLOCK);
        pulse(2);
        pulse(1);
        repeat (250) @(posedge CLOCK);
        chk("pending count", base + 2, pkts);
        chk("pending status", exp_word(3), last_pkt[79:64]);
        $display("pending test done");
        wr(ADDR_EVT_STAT, 8'h07);
        wr(ADDR_EVT_EN, 8'h00);
        base = pkts;
        pulse(2);
        wait_pkts(base + 1);
        repeat (4) @(posedge CLOCK);
        rd(ADDR_EVT_STAT, 8'h05, "event status");
        chk("masked irq", 64'h0, IRQ);
        wr(ADDR_EVT_EN, 8'h01);
        #1;
        chk("raised irq", 64'h1, IRQ);
        wr(ADDR_EVT_STAT, 8'h01);
        #1;
        chk("cleared irq", 64'h0, IRQ);
        rd(ADDR_EVT_STAT, 8'h04, "event status");
        $display("interrupt test done");
        test_done;
    end
endmodule : serial_state_notify_packet_tb_top
